// file: logic/smp_dev.sv
// spread modem configuration registers, map switch, data fifo, symbol timer
// assumes the controller end drives the link on the same clock
//
// Functional notes
// RULE_01: spreading 6..12 gives 64..4096 chips per symbol
// RULE_02: both link ends use identical spreading factor
// RULE_03: factor six requires headerless packet mode
// RULE_04: factor six: tuning register low bits 0b101
// RULE_05: factor six: threshold register loaded 0x0C
// RULE_06: coding codes 1..4 give 4/5..4/8 overhead
// RULE_07: coding rate may travel in header
// RULE_08: channel width is double sideband, 7.8..500 kHz
// RULE_09: low band forbids 250 and 500 kHz
// RULE_10: modem switch only while in sleep
// RULE_11: spread mode swaps in its own register map
// RULE_12: spread modem has own dual-port data fifo
// RULE_13: symbol lasts chips divided by channel width
// RULE_14: one bit in timeout register picks headerless
// RULE_15: host programs only defined spread and coding codes
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module smp_dev
  import smp_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  smp_link_if.dev link,
  output logic spread_mode_o,
  output logic [2:0] op_mode_o,
  output logic [3:0] chip_spread_value_o,
  output logic [2:0] fec_ratio_setting_o,
  output logic [3:0] channel_width_o,
  output logic headerless_packet_select_o,
  output logic header_fec_valid_o,
  output logic [12:0] chips_per_symbol_o,
  output logic [3:0] overhead_quarters_o,
  output logic symbol_tick_o,
  input wire logic fifo_pop_i,
  output logic [7:0] fifo_data_o,
  output logic fifo_data_valid_o,
  output logic fifo_empty_o
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [7:0] opmode;
    logic [7:0] txcfg1;
    logic [7:0] mcfg2;
    logic [7:0] symtmo;
    logic [7:0] sf6_low;
    logic [7:0] sf6_thr;
    logic [LEG_N-1:0][7:0] legacy;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [FIFO_AW:0] cnt;
    logic [7:0] rdata;
    logic ready;
    logic [7:0] dout;
    logic dv;
    logic [15:0] chip_cnt;
    logic [12:0] chip_idx;
    logic [12:0] cps;
    logic [3:0] oh;
    logic tick;
    logic hdr_fec;
    logic empty;
  } smp_dev_state_t;

  smp_dev_state_t s_q;
  smp_dev_state_t s_d;

  logic lr;
  logic active;
  logic reg_pop;
  logic modem_pop;
  logic push;
  logic [15:0] chip_len;

  // =====================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.dv = 1'b0;
    s_d.rdata = 8'h00;
    reg_pop = 1'b0;
    modem_pop = 1'b0;
    lr = s_q.opmode[OPM_LR_BIT];
    push = link.dat_valid && s_q.ready;

    // register writes
    if (link.wr) begin
      unique case (link.addr)
        A_OPMODE: begin
          s_d.opmode[MODE_W-1:0] = link.wdata[MODE_W-1:0];
          if (s_q.opmode[MODE_W-1:0] == MODE_SLEEP) begin
            s_d.opmode[OPM_LR_BIT] = link.wdata[OPM_LR_BIT]; // RULE_10
          end
        end
        A_TXCFG1: begin
          if (lr) s_d.txcfg1 = link.wdata; // RULE_11
          else s_d.legacy[0] = link.wdata;
        end
        A_MCFG2: begin
          if (lr) s_d.mcfg2 = link.wdata; // RULE_11
          else s_d.legacy[1] = link.wdata;
        end
        A_SYMTMO: begin
          if (lr) s_d.symtmo = link.wdata; // RULE_14
          else s_d.legacy[2] = link.wdata;
        end
        A_SF6_LOW: begin
          if (lr) s_d.sf6_low = link.wdata;
          else s_d.legacy[3] = link.wdata;
        end
        A_SF6_THR: begin
          if (lr) s_d.sf6_thr = link.wdata;
          else s_d.legacy[4] = link.wdata;
        end
        default: ;
      endcase
    end

    // register reads, answer in the next cycle
    if (link.rd) begin
      unique case (link.addr)
        A_FIFO: begin
          if (lr && s_q.cnt != '0) begin
            s_d.rdata = s_q.mem[s_q.rp]; // RULE_12
            reg_pop = 1'b1;
          end
        end
        A_OPMODE: s_d.rdata = s_q.opmode;
        A_TXCFG1: s_d.rdata = lr ? s_q.txcfg1 : s_q.legacy[0]; // RULE_11
        A_MCFG2: s_d.rdata = lr ? s_q.mcfg2 : s_q.legacy[1];
        A_SYMTMO: s_d.rdata = lr ? s_q.symtmo : s_q.legacy[2];
        A_SF6_LOW: s_d.rdata = lr ? s_q.sf6_low : s_q.legacy[3];
        A_SF6_THR: s_d.rdata = lr ? s_q.sf6_thr : s_q.legacy[4];
        default: s_d.rdata = 8'h00;
      endcase
    end

    // modem side of the fifo
    if (fifo_pop_i && s_q.cnt != '0) begin
      modem_pop = 1'b1;
      s_d.dout = s_q.mem[s_q.rp];
      s_d.dv = 1'b1;
    end

    // fifo bookkeeping, one pop even when both ports ask
    if (push) begin
      s_d.mem[s_q.wp] = link.dat; // RULE_12
      s_d.wp = s_q.wp + FIFO_AW'(1);
    end
    if (reg_pop || modem_pop) begin
      s_d.rp = s_q.rp + FIFO_AW'(1);
    end
    if (push && !(reg_pop || modem_pop)) begin
      s_d.cnt = s_q.cnt + (FIFO_AW+1)'(1);
    end else if (!push && (reg_pop || modem_pop)) begin
      s_d.cnt = s_q.cnt - (FIFO_AW+1)'(1);
    end
    s_d.ready = s_d.opmode[OPM_LR_BIT] &&
                (s_d.cnt < (FIFO_AW+1)'(FIFO_DEPTH - 1));
    s_d.empty = (s_d.cnt == '0);

    // derived modem parameters
    s_d.cps = 13'(1) << s_d.mcfg2[SF_LSB +: 4]; // RULE_01 RULE_02
    s_d.oh = CR_BASE + 4'(s_d.txcfg1[CR_LSB +: 3]); // RULE_06
    s_d.hdr_fec = ~s_d.symtmo[HDRLESS_BIT]; // RULE_07

    // symbol timer: chip count times chip period
    active = lr && (s_q.opmode[MODE_W-1:0] != MODE_SLEEP) &&
             (s_q.opmode[MODE_W-1:0] != MODE_STBY);
    chip_len = chip_cycles(CLK_FREQ_HZ, s_q.txcfg1[BW_LSB +: 4]); // RULE_08
    if (!active) begin
      s_d.chip_cnt = 16'h0000;
      s_d.chip_idx = 13'h0000;
    end else if (s_q.chip_cnt >= chip_len - 16'h0001) begin
      s_d.chip_cnt = 16'h0000;
      if (s_q.chip_idx >= s_q.cps - 13'h0001) begin
        s_d.chip_idx = 13'h0000;
        s_d.tick = 1'b1; // RULE_13
      end else begin
        s_d.chip_idx = s_q.chip_idx + 13'h0001;
      end
    end else begin
      s_d.chip_cnt = s_q.chip_cnt + 16'h0001;
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.opmode <= OPMODE_RST;
      s_q.txcfg1 <= TXCFG1_RST;
      s_q.mcfg2 <= MCFG2_RST;
      s_q.symtmo <= SYMTMO_RST;
      s_q.sf6_low <= SF6_LOW_RST;
      s_q.sf6_thr <= SF6_THR_RST;
      s_q.cps <= 13'h0080;
      s_q.oh <= 4'h5;
      s_q.hdr_fec <= 1'b1;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // outputs
  assign link.rdata = s_q.rdata;
  assign link.dat_ready = s_q.ready;
  assign spread_mode_o = s_q.opmode[OPM_LR_BIT];
  assign op_mode_o = s_q.opmode[MODE_W-1:0];
  assign chip_spread_value_o = s_q.mcfg2[SF_LSB +: 4];
  assign fec_ratio_setting_o = s_q.txcfg1[CR_LSB +: 3];
  assign channel_width_o = s_q.txcfg1[BW_LSB +: 4];
  assign headerless_packet_select_o = s_q.symtmo[HDRLESS_BIT];
  assign header_fec_valid_o = s_q.hdr_fec;
  assign chips_per_symbol_o = s_q.cps;
  assign overhead_quarters_o = s_q.oh;
  assign symbol_tick_o = s_q.tick;
  assign fifo_data_o = s_q.dout;
  assign fifo_data_valid_o = s_q.dv;
  assign fifo_empty_o = s_q.empty;

endmodule

// file: logic/smp_host.sv
// controller end: checks a configuration and loads it into the modem
// assumes the device end on the same clock answers reads one cycle later
`timescale 1ns/1ps
module smp_host
  import smp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  smp_link_if.host link,
  input wire logic [1:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o,
  output logic buf_ready_o,
  output logic busy_o
);

  // =====================================================================
  // state
  typedef enum logic [3:0] {
    H_IDLE = 4'h0,
    H_SLEEP = 4'h1,
    H_MODEM = 4'h2,
    H_CFG1 = 4'h3,
    H_CFG2 = 4'h4,
    H_TMO = 4'h5,
    H_RD31 = 4'h6,
    H_WT31 = 4'h7,
    H_WR31 = 4'h8,
    H_WR37 = 4'h9,
    H_STBY = 4'hA
  } smp_hstate_t;

  typedef struct packed {
    smp_hstate_t st;
    logic [15:0] cfg;
    logic busy;
    logic done;
    logic err;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [1:0][7:0] bm;
    logic [1:0] bv;
    logic rdy;
    logic [15:0] rdata;
  } smp_host_state_t;

  smp_host_state_t s_q;
  smp_host_state_t s_d;

  logic [3:0] sf;
  logic [2:0] cr;
  logic [3:0] bw;
  logic hl;
  logic lrt;
  logic bad;
  logic [2:0] status;

  // =====================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.rdata = 16'h0000;
    sf = s_q.cfg[C_SF_LSB +: 4];
    cr = s_q.cfg[C_CR_LSB +: 3];
    bw = s_q.cfg[C_BW_LSB +: 4];
    lrt = s_q.cfg[C_SPREAD];
    hl = s_q.cfg[C_HDRLESS] || (sf == SF_MIN); // RULE_03
    bad = (sf < SF_MIN) || (sf > SF_MAX) || // RULE_15
          (cr < CR_MIN) || (cr > CR_MAX) ||
          (bw > BW_MAX) ||
          (s_q.cfg[C_LOWBAND] && bw >= BW_250); // RULE_09
    status = {s_q.err, s_q.done, s_q.busy};

    // software port
    if (sw_wr_i) begin
      unique case (sw_addr_i)
        U_CFG: if (!s_q.busy) s_d.cfg = sw_wdata_i;
        U_CMD: begin
          if (sw_wdata_i[CMD_GO] && !s_q.busy) begin
            s_d.done = 1'b0;
            s_d.err = bad && lrt;
            if (!(bad && lrt)) begin
              s_d.busy = 1'b1;
              s_d.st = H_SLEEP;
            end
          end
        end
        U_STAT: ;
        U_DATA: ;
      endcase
    end
    if (sw_rd_i) begin
      unique case (sw_addr_i)
        U_CFG: s_d.rdata = s_q.cfg;
        U_CMD: s_d.rdata = 16'h0000;
        U_STAT: s_d.rdata = {12'h000, ~s_q.rdy, status};
        U_DATA: s_d.rdata = 16'h0000;
      endcase
    end

    // two-entry buffer toward the device fifo
    if (s_q.bv[0] && link.dat_ready) begin
      s_d.bm[0] = s_q.bm[1];
      s_d.bv = {1'b0, s_q.bv[1]};
    end
    if (sw_wr_i && sw_addr_i == U_DATA && s_q.rdy) begin
      if (!s_d.bv[0]) begin
        s_d.bm[0] = sw_wdata_i[7:0];
        s_d.bv[0] = 1'b1;
      end else begin
        s_d.bm[1] = sw_wdata_i[7:0];
        s_d.bv[1] = 1'b1;
      end
    end
    s_d.rdy = ~s_d.bv[1];

    // configuration sequence
    unique case (s_q.st)
      H_IDLE: ;
      H_SLEEP: begin
        s_d.wr = 1'b1;
        s_d.addr = A_OPMODE;
        s_d.wdata = {lrt, 4'h0, MODE_SLEEP};
        s_d.st = H_MODEM;
      end
      H_MODEM: begin
        s_d.wr = 1'b1; // RULE_10
        s_d.addr = A_OPMODE;
        s_d.wdata = {lrt, 4'h0, MODE_SLEEP};
        s_d.st = lrt ? H_CFG1 : H_STBY;
      end
      H_CFG1: begin
        s_d.wr = 1'b1;
        s_d.addr = A_TXCFG1;
        s_d.wdata = {bw, cr, 1'b0};
        s_d.st = H_CFG2;
      end
      H_CFG2: begin
        s_d.wr = 1'b1; // RULE_02
        s_d.addr = A_MCFG2;
        s_d.wdata = {sf, 4'h0};
        s_d.st = H_TMO;
      end
      H_TMO: begin
        s_d.wr = 1'b1;
        s_d.addr = A_SYMTMO;
        s_d.wdata = 8'(hl) << HDRLESS_BIT; // RULE_03
        s_d.st = (sf == SF_MIN) ? H_RD31 : H_STBY;
      end
      H_RD31: begin
        s_d.rd = 1'b1;
        s_d.addr = A_SF6_LOW;
        s_d.st = H_WT31;
      end
      H_WT31: s_d.st = H_WR31;
      H_WR31: begin
        s_d.wr = 1'b1; // RULE_04
        s_d.addr = A_SF6_LOW;
        s_d.wdata = (link.rdata & SF6_LOW_KEEP) | {5'h00, SF6_LOW_PAT};
        s_d.st = H_WR37;
      end
      H_WR37: begin
        s_d.wr = 1'b1; // RULE_05
        s_d.addr = A_SF6_THR;
        s_d.wdata = SF6_THR_VAL;
        s_d.st = H_STBY;
      end
      H_STBY: begin
        s_d.wr = 1'b1;
        s_d.addr = A_OPMODE;
        s_d.wdata = {lrt, 4'h0, (s_q.cfg[C_RUN] ? MODE_RUN : MODE_STBY)};
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st = H_IDLE;
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  // =====================================================================
  // registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.st <= H_IDLE;
      s_q.cfg <= CFG_RST;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // outputs
  assign link.addr = s_q.addr;
  assign link.wdata = s_q.wdata;
  assign link.wr = s_q.wr;
  assign link.rd = s_q.rd;
  assign link.dat = s_q.bm[0];
  assign link.dat_valid = s_q.bv[0];
  assign sw_rdata_o = s_q.rdata;
  assign buf_ready_o = s_q.rdy;
  assign busy_o = s_q.busy;

endmodule

// file: logic/smp_link_if.sv
// link between the modem device end and its controller
// assumes both ends share core_clk_i; the testbench binds the instance
`timescale 1ns/1ps
interface smp_link_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] dat;
  logic dat_valid;
  logic dat_ready;

  modport dev(input addr, input wdata, input wr, input rd,
              output rdata, input dat, input dat_valid,
              output dat_ready);
  modport host(output addr, output wdata, output wr, output rd,
               input rdata, output dat, output dat_valid,
               input dat_ready);
endinterface

// file: logic/smp_pkg.sv
// constants, register map and field layout of the spread modem link
// assumes one 100 MHz clock shared by both ends
package smp_pkg;

  // =====================================================================
  // device register map
  localparam logic [6:0] A_FIFO = 7'h00;
  localparam logic [6:0] A_OPMODE = 7'h01;
  localparam logic [6:0] A_TXCFG1 = 7'h1D;
  localparam logic [6:0] A_MCFG2 = 7'h1E;
  localparam logic [6:0] A_SYMTMO = 7'h1F;
  localparam logic [6:0] A_SF6_LOW = 7'h31;
  localparam logic [6:0] A_SF6_THR = 7'h37;

  // =====================================================================
  // field positions
  localparam int OPM_LR_BIT = 7;
  localparam int MODE_W = 3;
  localparam int BW_LSB = 4;
  localparam int CR_LSB = 1;
  localparam int SF_LSB = 4;
  localparam int HDRLESS_BIT = 2;

  // =====================================================================
  // modes and codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STBY = 3'h1;
  localparam logic [2:0] MODE_RUN = 3'h3;
  localparam logic [3:0] SF_MIN = 4'h6;
  localparam logic [3:0] SF_MAX = 4'hC;
  localparam logic [2:0] CR_MIN = 3'h1;
  localparam logic [2:0] CR_MAX = 3'h4;
  localparam logic [3:0] CR_BASE = 4'h4;
  localparam logic [3:0] BW_250 = 4'h8;
  localparam logic [3:0] BW_MAX = 4'h9;
  localparam logic [2:0] SF6_LOW_PAT = 3'h5;
  localparam logic [7:0] SF6_LOW_KEEP = 8'hF8;
  localparam logic [7:0] SF6_THR_VAL = 8'h0C;

  // =====================================================================
  // reset values
  localparam logic [7:0] OPMODE_RST = 8'h01;
  localparam logic [7:0] TXCFG1_RST = 8'h72;
  localparam logic [7:0] MCFG2_RST = 8'h70;
  localparam logic [7:0] SYMTMO_RST = 8'h00;
  localparam logic [7:0] SF6_LOW_RST = 8'hC3;
  localparam logic [7:0] SF6_THR_RST = 8'h0A;

  // =====================================================================
  // sizes and timing
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int LEG_N = 5;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BW_UNIT_HZ = 100;

  // =====================================================================
  // controller software registers
  localparam logic [1:0] U_CFG = 2'h0;
  localparam logic [1:0] U_CMD = 2'h1;
  localparam logic [1:0] U_STAT = 2'h2;
  localparam logic [1:0] U_DATA = 2'h3;
  localparam int C_SF_LSB = 0;
  localparam int C_CR_LSB = 4;
  localparam int C_BW_LSB = 7;
  localparam int C_HDRLESS = 11;
  localparam int C_SPREAD = 12;
  localparam int C_LOWBAND = 13;
  localparam int C_RUN = 14;
  localparam int CMD_GO = 0;
  localparam logic [15:0] CFG_RST = 16'h1077;

  // channel width in 100 Hz units per code
  function automatic int unsigned bw_units(input logic [3:0] code);
    unique case (code)
      4'h0: return 78;
      4'h1: return 104;
      4'h2: return 156;
      4'h3: return 208;
      4'h4: return 312;
      4'h5: return 417;
      4'h6: return 625;
      4'h7: return 1250;
      4'h8: return 2500;
      default: return 5000;
    endcase
  endfunction

  // clock cycles per chip, rounded down, at least one
  function automatic logic [15:0] chip_cycles(input int unsigned clk_hz,
                                              input logic [3:0] code);
    int unsigned c;
    c = clk_hz / (bw_units(code) * BW_UNIT_HZ);
    if (c == 0) c = 1;
    return 16'(c);
  endfunction

endpackage

// file: sim/smp_link_asserts.sv
// link checker: assertions on the link between controller and modem
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module smp_link_asserts
  import smp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] dat,
  input wire logic dat_valid,
  input wire logic dat_ready
);
  // ======================================================================
  // helper: operating mode as the device holds it
  logic [7:0] op_q;
  logic [7:0] op_d;
  always_comb begin
    op_d = op_q;
    if (wr && addr == A_OPMODE) begin
      op_d[2:0] = wdata[2:0];
      if (op_q[2:0] == MODE_SLEEP) op_d[7] = wdata[7];
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) op_q <= OPMODE_RST;
    else op_q <= op_d;
  end

  // ======================================================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  strobe_excl_a: assert property (!(wr && rd))
    else $error("read and write strobes together");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  rd_pulse_a: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  dat_hold_a: assert property (dat_valid && !dat_ready |=>
    dat_valid && $stable(dat))
    else $error("stream byte dropped or changed before taken");
  sf6_hdr_a: assert property (wr && addr == A_MCFG2 &&
    wdata[7:4] == SF_MIN |=> wr && addr == A_SYMTMO && wdata[HDRLESS_BIT])
    else $error("factor six without headerless write");
  low_pat_a: assert property (wr && addr == A_SF6_LOW && op_q[7] |->
    wdata[2:0] == SF6_LOW_PAT && $past(rd, 2) &&
    $past(addr, 2) == A_SF6_LOW &&
    (wdata & SF6_LOW_KEEP) == ($past(rdata) & SF6_LOW_KEEP))
    else $error("tuning low bits write wrong");
  thr_val_a: assert property (wr && addr == A_SF6_THR && op_q[7] |->
    wdata == SF6_THR_VAL)
    else $error("threshold value wrong");
  mode_sleep_a: assert property (wr && addr == A_OPMODE &&
    wdata[2:0] != MODE_SLEEP |-> op_q[2:0] == MODE_SLEEP &&
    op_q[7] == wdata[7])
    else $error("modem switch outside sleep");

  sf6_c: cover property (wr && addr == A_SF6_THR);
  stream_c: cover property (dat_valid && dat_ready);
  legacy_c: cover property (wr && addr == A_OPMODE && wdata == 8'h01);
endmodule

// file: sim/tb_spread_modem_param_config.sv
// testbench: controller and modem joined by the link, driven by software
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ps
module tb_spread_modem_param_config
  import smp_pkg::*;
;
  logic core_clk_i;
  logic reset_n_i;
  logic fifo_pop_i;
  logic [1:0] sw_addr_i;
  logic [15:0] sw_wdata_i;
  logic sw_wr_i;
  logic sw_rd_i;
  logic [15:0] sw_rdata_o;
  logic buf_ready_o;
  logic busy_o;
  logic spread_mode_o;
  logic [2:0] op_mode_o;
  logic [3:0] chip_spread_value_o;
  logic [2:0] fec_ratio_setting_o;
  logic [3:0] channel_width_o;
  logic headerless_packet_select_o;
  logic header_fec_valid_o;
  logic [12:0] chips_per_symbol_o;
  logic [3:0] overhead_quarters_o;
  logic symbol_tick_o;
  logic [7:0] fifo_data_o;
  logic fifo_data_valid_o;
  logic fifo_empty_o;
  int error_cnt;
  int comparisons;
  int cyc;

  // ======================================================================
  // design
  smp_link_if smp_link_if_inst();
  smp_dev #(.CLK_FREQ_HZ(1000000)) smp_dev_inst(.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .link(smp_link_if_inst),
    .spread_mode_o(spread_mode_o), .op_mode_o(op_mode_o),
    .chip_spread_value_o(chip_spread_value_o),
    .fec_ratio_setting_o(fec_ratio_setting_o),
    .channel_width_o(channel_width_o),
    .headerless_packet_select_o(headerless_packet_select_o),
    .header_fec_valid_o(header_fec_valid_o),
    .chips_per_symbol_o(chips_per_symbol_o),
    .overhead_quarters_o(overhead_quarters_o),
    .symbol_tick_o(symbol_tick_o), .fifo_pop_i(fifo_pop_i),
    .fifo_data_o(fifo_data_o), .fifo_data_valid_o(fifo_data_valid_o),
    .fifo_empty_o(fifo_empty_o));
  smp_host smp_host_inst(.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .link(smp_link_if_inst), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o), .buf_ready_o(buf_ready_o), .busy_o(busy_o));
  smp_link_asserts smp_link_asserts_inst(.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .addr(smp_link_if_inst.addr),
    .wdata(smp_link_if_inst.wdata), .wr(smp_link_if_inst.wr),
    .rd(smp_link_if_inst.rd), .rdata(smp_link_if_inst.rdata),
    .dat(smp_link_if_inst.dat), .dat_valid(smp_link_if_inst.dat_valid),
    .dat_ready(smp_link_if_inst.dat_ready));

  // ======================================================================
  // clock, timeout and helpers
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [33:0] snap();
    return {spread_mode_o, op_mode_o, chip_spread_value_o,
      fec_ratio_setting_o, channel_width_o, headerless_packet_select_o,
      header_fec_valid_o, chips_per_symbol_o, overhead_quarters_o};
  endfunction

  function automatic logic [33:0] expd(input logic sp, input logic [3:0] sf,
    input logic [2:0] cr, input logic [3:0] bw);
    logic hl;
    hl = (sf == SF_MIN);
    return {sp, MODE_STBY, sf, cr, bw, hl, ~hl, 13'(1) << sf,
      4'(cr) + CR_BASE};
  endfunction

  function automatic logic [15:0] mkcfg(input logic [3:0] sf,
    input logic [2:0] cr, input logic [3:0] bw, input logic sp,
    input logic lb);
    return {2'b00, lb, sp, 1'b0, bw, cr, sf};
  endfunction

  task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sw_wr_i <= 1'b0;
  endtask

  task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask

  task automatic cfg_go(input logic [15:0] c);
    int n;
    sw_wr(U_CFG, c);
    sw_wr(U_CMD, 16'h0001);
    @(posedge core_clk_i);
    n = 0;
    #1;
    while (busy_o === 1'b1 && n < 200) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    // the closing mode write is taken one edge after busy falls
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic pop(input logic [7:0] b);
    @(posedge core_clk_i);
    fifo_pop_i <= 1'b1;
    @(posedge core_clk_i);
    fifo_pop_i <= 1'b0;
    #1 chk(34'({fifo_data_valid_o, fifo_data_o}), 34'({1'b1, b}));
  endtask

  // ======================================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] d;
    chk(snap(), expd(1'b0, 4'h7, 3'h1, 4'h7));
    sw_rd(U_CFG, d);
    chk(34'(d), 34'(CFG_RST));
    chk(34'(fifo_empty_o), 34'h1);
    $display("test reset done");
  endtask

  task automatic t_codes();
    logic [15:0] d;
    logic [3:0] sf;
    logic [2:0] cr;
    for (int i = 0; i < 10; i++) begin
      sf = 4'(6 + i % 7);
      cr = 3'(1 + i % 4);
      cfg_go(mkcfg(sf, cr, 4'(i), 1'b1, 1'b0));
      chk(snap(), expd(1'b1, sf, cr, 4'(i)));
      sw_rd(U_STAT, d);
      chk(34'(d[3:0]), 34'h2);
    end
    $display("test codes done");
  endtask

  task automatic t_bad();
    logic [15:0] d;
    logic [33:0] s0;
    logic [15:0] bad [6];
    bad = '{mkcfg(4'h5, 3'h1, 4'h7, 1'b1, 1'b0),
      mkcfg(4'hD, 3'h1, 4'h7, 1'b1, 1'b0),
      mkcfg(4'h7, 3'h0, 4'h7, 1'b1, 1'b0),
      mkcfg(4'h7, 3'h5, 4'h7, 1'b1, 1'b0),
      mkcfg(4'h7, 3'h1, BW_250, 1'b1, 1'b1),
      mkcfg(4'h7, 3'h1, BW_MAX, 1'b1, 1'b1)};
    s0 = snap();
    foreach (bad[j]) begin
      cfg_go(bad[j]);
      chk(snap(), s0);
      sw_rd(U_STAT, d);
      chk(34'(d[2]), 34'h1);
    end
    cfg_go(mkcfg(4'h7, 3'h1, 4'h7, 1'b1, 1'b1));
    chk(snap(), expd(1'b1, 4'h7, 3'h1, 4'h7));
    $display("test bad codes done");
  endtask

  task automatic t_stream();
    logic [15:0] d;
    for (int i = 0; i < 20; i++) sw_wr(U_DATA, 16'(8'h40 + i));
    repeat (4) @(posedge core_clk_i);
    sw_rd(U_STAT, d);
    chk(34'(d[3]), 34'h1);
    for (int k = 0; k < 17; k++) pop(8'(8'h40 + k));
    repeat (3) @(posedge core_clk_i);
    chk(34'(fifo_empty_o), 34'h1);
    $display("test stream done");
  endtask

  task automatic t_legacy();
    logic [33:0] s0;
    s0 = snap();
    cfg_go(mkcfg(4'h8, 3'h2, 4'h7, 1'b0, 1'b0));
    chk(snap(), {1'b0, s0[32:0]});
    sw_wr(U_DATA, 16'h005A);
    repeat (4) @(posedge core_clk_i);
    chk(34'(fifo_empty_o), 34'h1);
    cfg_go(mkcfg(4'h7, 3'h1, 4'h7, 1'b1, 1'b0));
    chk(snap(), expd(1'b1, 4'h7, 3'h1, 4'h7));
    repeat (3) @(posedge core_clk_i);
    pop(8'h5A);
    $display("test legacy switch done");
  endtask

  task automatic t_tick();
    int n;
    cfg_go(mkcfg(4'h6, 3'h1, 4'h7, 1'b1, 1'b0) | (16'h0001 << C_RUN));
    chk(34'(op_mode_o), 34'(MODE_RUN));
    n = 0;
    while (symbol_tick_o !== 1'b1 && n < 2000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (symbol_tick_o !== 1'b1 && n < 2000);
    chk(34'(n), 34'(64 * (1000000 / 125000)));
    $display("test symbol timer done");
  endtask

  initial begin
    core_clk_i = 1'b0;
    reset_n_i = 1'b0;
    fifo_pop_i = 1'b0;
    sw_addr_i = 2'h0;
    sw_wdata_i = 16'h0000;
    sw_wr_i = 1'b0;
    sw_rd_i = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_codes();
    t_bad();
    t_stream();
    t_legacy();
    t_tick();
    close_out();
  end
endmodule
